// *** shared/dldlc_pkg.sv ***
// Constants, field layout and carrier types for the dual-loop lock and divider block.
// Assumes one core clock; every pin input is synchronous to it.
// Behaviour
// [RQ1] First-loop lock rises after programmed count of in-window detector cycles; zero reserved.
// [RQ2] Second-loop lock counter increments on each in-window detector cycle. Code holds it at the target once the target is reached.
// [RQ3] Software programs the second-loop window code to 2 only.
// [RQ4] Doubler bit 1 feeds second-loop reference at twice the oscillator rate.
// [RQ5] Software uses second-loop reference divide of 1 only with the doubler.
// [RQ6] Second-loop polarity bit: 0 negative slope, 1 positive; internal VCO needs 0.
// [RQ7] Second-loop pump current codes give 100, 400, 1600, 3200 uA.
// [RQ8] Second-loop high-Z bit floats the second pump output whatever the current.
// [RQ9] Second-loop lock rises after programmed consecutive in-window cycles; zero reserved.
// [RQ10] First-loop polarity bit: 0 negative slope, 1 positive slope.
// [RQ11] First-loop pump current codes give 100, 200, 400, 1600 uA.
// [RQ12] First-loop high-Z bit floats the first pump output.
// [RQ13] Each clock input has a 2-bit pre-divider dividing by 1, 2, 4, 8.
// [RQ14] Pre-divider of the currently active input feeds the first-loop reference divider.
// [RQ15] First-loop reference divider divides by its 14-bit field value.
// [RQ16] Second-loop reference divider divides by its 12-bit field value.
// [RQ17] First-loop feedback divider divides by its field value.
// [RQ18] Software sets the oscillator range field before running VCO calibration.
// [RQ19] Range codes 0,1,2,4 mean up to 63, 127, 255, 400 MHz; 3 reserved.
// [RQ20] First-loop window codes select 5.5, 10, 18.6 or 40 ns.
// [RQ21] While write protect is set, writes to registers 0 to 30 are ignored.
// [RQ22] Out-of-window detector cycle clears lock counter and drops lock.

package dldlc_pkg;

    // ==========================================================
    // Serial word
    localparam int unsigned WORD_BITS = 32;
    localparam int unsigned ADDR_MSB  = 4;

    // ==========================================================
    // Register addresses
    localparam logic [4:0] ADDR_LOOP1_WINDOW   = 5'h18;
    localparam logic [4:0] ADDR_LOOP1_LOCK     = 5'h19;
    localparam logic [4:0] ADDR_LOOP2_LOCK_CP  = 5'h1a;
    localparam logic [4:0] ADDR_LOOP1_CP_RDIV  = 5'h1b;
    localparam logic [4:0] ADDR_LOOP2R_LOOP1N  = 5'h1c;
    localparam logic [4:0] ADDR_OSC_RANGE      = 5'h1d;
    localparam logic [4:0] ADDR_WRITE_PROTECT  = 5'h1f;

    // ==========================================================
    // Field positions
    localparam int unsigned LOOP1_WIN_LSB   = 6;
    localparam int unsigned DLD_CNT_LSB     = 6;
    localparam int unsigned LOOP2_WIN_LSB   = 30;
    localparam int unsigned DOUBLER_BIT     = 29;
    localparam int unsigned POL_BIT         = 28;
    localparam int unsigned CP_GAIN_LSB     = 26;
    localparam int unsigned TRI_BIT         = 5;
    localparam int unsigned PRE2_LSB        = 24;
    localparam int unsigned PRE1_LSB        = 22;
    localparam int unsigned PRE0_LSB        = 20;
    localparam int unsigned R1_LSB          = 6;
    localparam int unsigned R2_LSB          = 20;
    localparam int unsigned N1_LSB          = 6;
    localparam int unsigned OSC_RANGE_LSB   = 24;
    localparam int unsigned PROTECT_BIT     = 5;

    // ==========================================================
    // Values after reset
    localparam logic [31:0] RST_LOOP1_WINDOW  = 32'h0000_0000;
    localparam logic [31:0] RST_LOOP1_LOCK    = 32'h0000_0040;
    localparam logic [31:0] RST_LOOP2_LOCK_CP = 32'h8000_0040;
    localparam logic [31:0] RST_LOOP1_CP_RDIV = 32'h0000_0040;
    localparam logic [31:0] RST_LOOP2R_LOOP1N = 32'h0010_0040;
    localparam logic [31:0] RST_OSC_RANGE     = 32'h0000_0000;
    localparam logic       RST_PROTECT       = 1'b0;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic        positive_slope;
        logic [11:0] current_ua;
        logic        drive_en;
    } dldlc_pump_t;

    typedef struct packed {
        logic [2:0] code;
        logic [8:0] max_mhz;
        logic       valid;
    } dldlc_osc_range_t;

endpackage

// *** design/dldlc_core.sv ***
// Register file, reference/feedback dividers and digital lock detect of both loops.
// Assumes serial pins, clock inputs and window comparator flags are synchronous to core_clk_i.

`timescale 1ns/10ps
`default_nettype none

module dldlc_core (
    // Clock, reset, enable
    input  wire logic                      core_clk_i,
    input  wire logic                      rstn_i,
    input  wire logic                      ce_i,
    // Serial configuration pins
    input  wire logic                      ser_clk_i,
    input  wire logic                      ser_data_i,
    input  wire logic                      ser_latch_i,
    // Reference and oscillator clocks
    input  wire logic [2:0]                clk_in_i,
    input  wire logic [1:0]                active_input_i,
    input  wire logic                      oscillator_input_i,
    input  wire logic                      vcxo_fb_i,
    // Phase window comparators, one flag per window code
    input  wire logic [3:0]                loop1_in_window_i,
    input  wire logic [3:0]                loop2_in_window_i,
    // Detector strobes
    output logic                           first_loop_ref_pulse_o,
    output logic                           first_loop_fb_pulse_o,
    output logic                           second_loop_ref_pulse_o,
    // Lock and pump controls
    output logic                           first_loop_lock_o,
    output logic                           second_loop_lock_o,
    output dldlc_pkg::dldlc_pump_t         first_pump_output_o,
    output dldlc_pkg::dldlc_pump_t         second_pump_output_o,
    output dldlc_pkg::dldlc_osc_range_t    osc_input_freq_range_o,
    output logic                           config_write_protect_o
);

    // ==========================================================
    // Helpers
    function automatic logic [14:0] div_step(input logic [13:0] cnt, input logic [13:0] div);
        logic hit;
        hit = (div <= 14'h0001) || (cnt >= div - 14'h0001);
        return {hit, hit ? 14'h0000 : cnt + 14'h0001};
    endfunction

    function automatic logic [14:0] lock_step(input logic [13:0] cnt, input logic [13:0] tgt,
                                             input logic in_win);
        logic [13:0] nxt;
        // Clamp to target so a lowered target still locks
        nxt = !in_win ? 14'h0000 : (cnt < tgt) ? cnt + 14'h0001 : tgt;
        return {(tgt != 14'h0000) && (nxt == tgt), nxt};
    endfunction

    // ==========================================================
    // Serial shift and latch
    logic [31:0] shift_reg;
    logic        ser_clk_prev_reg;
    logic        latch_prev_reg;
    logic        wr_fire;
    logic [4:0]  wr_addr;
    logic        wr_allowed;

    assign wr_fire    = ce_i && ser_latch_i && !latch_prev_reg;
    assign wr_addr    = shift_reg[dldlc_pkg::ADDR_MSB:0];
    assign wr_allowed = wr_fire && (!config_write_protect_o
                        || wr_addr == dldlc_pkg::ADDR_WRITE_PROTECT); // RQ21

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shift_reg        <= 32'h0000_0000;
            ser_clk_prev_reg <= 1'b0;
            latch_prev_reg   <= 1'b0;
        end else if (ce_i) begin
            ser_clk_prev_reg <= ser_clk_i;
            latch_prev_reg   <= ser_latch_i;
            if (ser_clk_i && !ser_clk_prev_reg && !ser_latch_i) begin
                shift_reg <= {shift_reg[30:0], ser_data_i};
            end
        end
    end

    // ==========================================================
    // Configuration registers
    logic [31:0] loop1_window_reg;
    logic [31:0] loop1_lock_reg;
    logic [31:0] loop2_lock_cp_reg;
    logic [31:0] loop1_cp_rdiv_reg;
    logic [31:0] loop2r_loop1n_reg;
    logic [31:0] osc_range_reg;
    logic        protect_reg;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            loop1_window_reg  <= dldlc_pkg::RST_LOOP1_WINDOW;
            loop1_lock_reg    <= dldlc_pkg::RST_LOOP1_LOCK;
            loop2_lock_cp_reg <= dldlc_pkg::RST_LOOP2_LOCK_CP;
            loop1_cp_rdiv_reg <= dldlc_pkg::RST_LOOP1_CP_RDIV;
            loop2r_loop1n_reg <= dldlc_pkg::RST_LOOP2R_LOOP1N;
            osc_range_reg     <= dldlc_pkg::RST_OSC_RANGE;
            protect_reg       <= dldlc_pkg::RST_PROTECT;
        end else if (wr_allowed) begin // RQ21
            case (wr_addr)
                dldlc_pkg::ADDR_LOOP1_WINDOW:  loop1_window_reg  <= shift_reg;
                dldlc_pkg::ADDR_LOOP1_LOCK:    loop1_lock_reg    <= shift_reg;
                dldlc_pkg::ADDR_LOOP2_LOCK_CP: loop2_lock_cp_reg <= shift_reg;
                dldlc_pkg::ADDR_LOOP1_CP_RDIV: loop1_cp_rdiv_reg <= shift_reg;
                dldlc_pkg::ADDR_LOOP2R_LOOP1N: loop2r_loop1n_reg <= shift_reg;
                dldlc_pkg::ADDR_OSC_RANGE:     osc_range_reg     <= shift_reg;
                dldlc_pkg::ADDR_WRITE_PROTECT: protect_reg       <= shift_reg[dldlc_pkg::PROTECT_BIT];
                default: begin
                end
            endcase
        end
    end

    assign config_write_protect_o = protect_reg;

    // ==========================================================
    // Field views
    logic [1:0]  win1_code;
    logic [1:0]  win2_code;
    logic [13:0] tgt1;
    logic [13:0] tgt2;
    logic [13:0] r1_div;
    logic [13:0] r2_div;
    logic [13:0] n1_div;
    logic [1:0]  pre_code;
    logic        doubler;

    assign win1_code = loop1_window_reg[dldlc_pkg::LOOP1_WIN_LSB +: 2];
    assign win2_code = loop2_lock_cp_reg[dldlc_pkg::LOOP2_WIN_LSB +: 2];
    assign tgt1      = loop1_lock_reg[dldlc_pkg::DLD_CNT_LSB +: 14];
    assign tgt2      = loop2_lock_cp_reg[dldlc_pkg::DLD_CNT_LSB +: 14];
    assign r1_div    = loop1_cp_rdiv_reg[dldlc_pkg::R1_LSB +: 14];
    assign r2_div    = {2'b00, loop2r_loop1n_reg[dldlc_pkg::R2_LSB +: 12]};
    assign n1_div    = loop2r_loop1n_reg[dldlc_pkg::N1_LSB +: 14];
    assign doubler   = loop2_lock_cp_reg[dldlc_pkg::DOUBLER_BIT];

    always_comb begin
        case (active_input_i) // RQ14
            2'd0:    pre_code = loop1_cp_rdiv_reg[dldlc_pkg::PRE0_LSB +: 2]; // RQ13
            2'd1:    pre_code = loop1_cp_rdiv_reg[dldlc_pkg::PRE1_LSB +: 2];
            2'd2:    pre_code = loop1_cp_rdiv_reg[dldlc_pkg::PRE2_LSB +: 2];
            default: pre_code = 2'd0;
        endcase
    end

    // ==========================================================
    // Edge detection of clock pins
    logic [2:0] clk_in_prev_reg;
    logic [1:0] active_prev_reg;
    logic       osc_prev_reg;
    logic       vcxo_prev_reg;
    logic       ref_edge;
    logic       osc_tick;
    logic       vcxo_edge;

    assign ref_edge  = (active_input_i != 2'd3)
                       && clk_in_i[active_input_i] && !clk_in_prev_reg[active_input_i];
    assign osc_tick  = doubler ? (oscillator_input_i ^ osc_prev_reg)
                               : (oscillator_input_i && !osc_prev_reg); // RQ4
    assign vcxo_edge = vcxo_fb_i && !vcxo_prev_reg;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clk_in_prev_reg <= 3'b000;
            active_prev_reg <= 2'd0;
            osc_prev_reg    <= 1'b0;
            vcxo_prev_reg   <= 1'b0;
        end else if (ce_i) begin
            clk_in_prev_reg <= clk_in_i;
            active_prev_reg <= active_input_i;
            osc_prev_reg    <= oscillator_input_i;
            vcxo_prev_reg   <= vcxo_fb_i;
        end
    end

    // ==========================================================
    // Pre-divider and first-loop reference divider
    logic [2:0]  pre_cnt_reg;
    logic        pre_pulse;
    logic [14:0] r1_step;
    logic [13:0] r1_cnt_reg;

    assign pre_pulse = ref_edge && (pre_cnt_reg >= (3'd1 << pre_code) - 3'd1); // RQ13
    assign r1_step   = div_step(r1_cnt_reg, r1_div);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre_cnt_reg            <= 3'd0;
            r1_cnt_reg             <= 14'h0000;
            first_loop_ref_pulse_o <= 1'b0;
        end else if (ce_i) begin
            first_loop_ref_pulse_o <= pre_pulse && r1_step[14]; // RQ15
            if (active_input_i != active_prev_reg) begin
                pre_cnt_reg <= 3'd0; // RQ14
            end else if (ref_edge) begin
                pre_cnt_reg <= pre_pulse ? 3'd0 : pre_cnt_reg + 3'd1;
            end
            if (pre_pulse) begin
                r1_cnt_reg <= r1_step[13:0]; // RQ15
            end
        end
    end

    // ==========================================================
    // First-loop feedback and second-loop reference dividers
    logic [14:0] n1_step;
    logic [14:0] r2_step;
    logic [13:0] n1_cnt_reg;
    logic [13:0] r2_cnt_reg;

    assign n1_step = div_step(n1_cnt_reg, n1_div);
    assign r2_step = div_step(r2_cnt_reg, r2_div);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            n1_cnt_reg              <= 14'h0000;
            r2_cnt_reg              <= 14'h0000;
            first_loop_fb_pulse_o   <= 1'b0;
            second_loop_ref_pulse_o <= 1'b0;
        end else if (ce_i) begin
            first_loop_fb_pulse_o   <= vcxo_edge && n1_step[14]; // RQ17
            second_loop_ref_pulse_o <= osc_tick && r2_step[14]; // RQ16
            if (vcxo_edge) begin
                n1_cnt_reg <= n1_step[13:0];
            end
            if (osc_tick) begin
                r2_cnt_reg <= r2_step[13:0];
            end
        end
    end

    // ==========================================================
    // Digital lock detect
    logic        win1_ok;
    logic        win2_ok;
    logic [14:0] lk1_step;
    logic [14:0] lk2_step;
    logic [13:0] lk1_cnt_reg;
    logic [13:0] lk2_cnt_reg;

    assign win1_ok  = loop1_in_window_i[win1_code]; // RQ20
    assign win2_ok  = loop2_in_window_i[win2_code]; // RQ3
    assign lk1_step = lock_step(lk1_cnt_reg, tgt1, win1_ok);
    assign lk2_step = lock_step(lk2_cnt_reg, tgt2, win2_ok);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lk1_cnt_reg       <= 14'h0000;
            first_loop_lock_o <= 1'b0;
        end else if (ce_i && first_loop_ref_pulse_o) begin
            lk1_cnt_reg       <= lk1_step[13:0]; // RQ20 RQ22
            first_loop_lock_o <= lk1_step[14]; // RQ1
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lk2_cnt_reg        <= 14'h0000;
            second_loop_lock_o <= 1'b0;
        end else if (ce_i && second_loop_ref_pulse_o) begin
            lk2_cnt_reg        <= lk2_step[13:0]; // RQ2 RQ22
            second_loop_lock_o <= lk2_step[14]; // RQ9
        end
    end

    // ==========================================================
    // Pump controls and oscillator range
    always_comb begin
        first_pump_output_o.positive_slope  = loop1_cp_rdiv_reg[dldlc_pkg::POL_BIT]; // RQ10
        first_pump_output_o.drive_en        = !loop1_cp_rdiv_reg[dldlc_pkg::TRI_BIT]; // RQ12
        case (loop1_cp_rdiv_reg[dldlc_pkg::CP_GAIN_LSB +: 2]) // RQ11
            2'd0:    first_pump_output_o.current_ua = 12'd100;
            2'd1:    first_pump_output_o.current_ua = 12'd200;
            2'd2:    first_pump_output_o.current_ua = 12'd400;
            default: first_pump_output_o.current_ua = 12'd1600;
        endcase
        second_pump_output_o.positive_slope = loop2_lock_cp_reg[dldlc_pkg::POL_BIT]; // RQ6
        second_pump_output_o.drive_en       = !loop2_lock_cp_reg[dldlc_pkg::TRI_BIT]; // RQ8
        case (loop2_lock_cp_reg[dldlc_pkg::CP_GAIN_LSB +: 2]) // RQ7
            2'd0:    second_pump_output_o.current_ua = 12'd100;
            2'd1:    second_pump_output_o.current_ua = 12'd400;
            2'd2:    second_pump_output_o.current_ua = 12'd1600;
            default: second_pump_output_o.current_ua = 12'd3200;
        endcase
        osc_input_freq_range_o.code = osc_range_reg[dldlc_pkg::OSC_RANGE_LSB +: 3];
        osc_input_freq_range_o.valid = 1'b1;
        case (osc_input_freq_range_o.code) // RQ19
            3'd0:    osc_input_freq_range_o.max_mhz = 9'd63;
            3'd1:    osc_input_freq_range_o.max_mhz = 9'd127;
            3'd2:    osc_input_freq_range_o.max_mhz = 9'd255;
            3'd4:    osc_input_freq_range_o.max_mhz = 9'd400;
            default: begin
                osc_input_freq_range_o.max_mhz = 9'd0;
                osc_input_freq_range_o.valid   = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Assertions
    sequence s_write(logic [4:0] a);
        wr_allowed && wr_addr == a;
    endsequence

    sequence s_pd1_miss;
        ce_i && first_loop_ref_pulse_o && !win1_ok;
    endsequence

    a_lock1_at_target: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // RQ1
        $rose(first_loop_lock_o) |-> (lk1_cnt_reg == tgt1) && (tgt1 != 14'h0000))
        else $error("first loop lock rose before target count");

    a_lock1_drop_out: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // RQ22
        s_pd1_miss |=> !first_loop_lock_o && lk1_cnt_reg == 14'h0000)
        else $error("first loop lock kept after out-of-window cycle");

    a_lock2_count_up: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // RQ2
        ce_i && second_loop_ref_pulse_o && win2_ok && lk2_cnt_reg < tgt2
        |=> lk2_cnt_reg == $past(lk2_cnt_reg) + 14'h0001)
        else $error("second loop lock counter did not advance");

    a_lock2_at_target: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // RQ9
        second_loop_lock_o |-> lk2_cnt_reg == tgt2 && tgt2 != 14'h0000)
        else $error("second loop lock without full count");

    a_pump2_high_z: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // RQ8
        s_write(dldlc_pkg::ADDR_LOOP2_LOCK_CP) ##0 shift_reg[dldlc_pkg::TRI_BIT]
        |=> !second_pump_output_o.drive_en)
        else $error("second pump driven while high-Z set");

    a_pump1_current: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // RQ11
        s_write(dldlc_pkg::ADDR_LOOP1_CP_RDIV) ##0 shift_reg[27:26] == 2'd3
        |=> first_pump_output_o.current_ua == 12'd1600)
        else $error("first pump current code 3 not 1600 uA");

    a_protect_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // RQ21
        wr_fire && protect_reg && wr_addr != dldlc_pkg::ADDR_WRITE_PROTECT
        |=> $stable(loop1_cp_rdiv_reg) && $stable(loop2_lock_cp_reg)
            && $stable(loop2r_loop1n_reg) && $stable(osc_range_reg))
        else $error("write accepted while protected");

    a_prediv_bypass: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // RQ13
        ce_i && ref_edge && pre_code == 2'd0 && r1_div == 14'h0001
        |=> first_loop_ref_pulse_o)
        else $error("divide-by-one path dropped an edge");

    a_doubler_fall: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // RQ4
        ce_i && doubler && !oscillator_input_i && osc_prev_reg && r2_div == 14'h0001
        |=> second_loop_ref_pulse_o)
        else $error("doubler ignored falling edge");

endmodule

`default_nettype wire

// *** testbench/tb_dual_loop_divider_lock_config.sv ***
// Self-checking bench for the dual-loop lock and divider core.
// Assumes dldlc_pkg is compiled first; drives every input on the falling clock edge.
`timescale 1ns/10ps
`default_nettype none

module tb_dual_loop_divider_lock_config;
    typedef struct packed {
        logic [1:0]  sel;
        logic [31:0] word;
        logic [13:0] exp;
        logic [13:0] mask;
    } dldlc_row_t;

    logic core_clk_i, rstn_i, ser_clk_i, ser_data_i, ser_latch_i, oscillator_input_i, vcxo_fb_i;
    logic ce_i;
    logic [2:0] clk_in_i;
    logic [1:0] active_input_i;
    logic [3:0] loop1_in_window_i, loop2_in_window_i;
    logic ref1, fb1, ref2, lock1, lock2, protect;
    dldlc_pkg::dldlc_pump_t      p1, p2;
    dldlc_pkg::dldlc_osc_range_t osc;
    int n_mismatch, cmp_count, n_ref1, n_fb1, n_ref2;

    // ==========================================
    // Pump and range decode table
    dldlc_row_t rows [14] = '{
        '{2'h1, 32'h9C00_005A, 14'h3901, 14'h3FFF}, '{2'h1, 32'h8400_005A, 14'h0321, 14'h3FFF},
        '{2'h1, 32'h8800_007A, 14'h0000, 14'h0001}, '{2'h1, 32'h8000_005A, 14'h00C9, 14'h3FFF},
        '{2'h0, 32'h1000_005B, 14'h20C9, 14'h3FFF}, '{2'h0, 32'h0400_005B, 14'h0191, 14'h3FFF},
        '{2'h0, 32'h0800_005B, 14'h0321, 14'h3FFF}, '{2'h0, 32'h0C00_007B, 14'h0000, 14'h0001},
        '{2'h0, 32'h0C00_005B, 14'h0C81, 14'h3FFF}, '{2'h2, 32'h0000_001D, 14'h007F, 14'h3FFF},
        '{2'h2, 32'h0100_001D, 14'h04FF, 14'h3FFF}, '{2'h2, 32'h0300_001D, 14'h0C00, 14'h3FFF},
        '{2'h2, 32'h0400_001D, 14'h1321, 14'h3FFF}, '{2'h2, 32'h0200_001D, 14'h09FF, 14'h3FFF}};

    dldlc_core uut (
        .core_clk_i             (core_clk_i),
        .rstn_i                 (rstn_i),
        .ce_i                   (ce_i),
        .ser_clk_i              (ser_clk_i),
        .ser_data_i             (ser_data_i),
        .ser_latch_i            (ser_latch_i),
        .clk_in_i               (clk_in_i),
        .active_input_i         (active_input_i),
        .oscillator_input_i     (oscillator_input_i),
        .vcxo_fb_i              (vcxo_fb_i),
        .loop1_in_window_i      (loop1_in_window_i),
        .loop2_in_window_i      (loop2_in_window_i),
        .first_loop_ref_pulse_o (ref1),
        .first_loop_fb_pulse_o  (fb1),
        .second_loop_ref_pulse_o(ref2),
        .first_loop_lock_o      (lock1),
        .second_loop_lock_o     (lock2),
        .first_pump_output_o    (p1),
        .second_pump_output_o   (p2),
        .osc_input_freq_range_o (osc),
        .config_write_protect_o (protect)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        if (ref1 === 1'b1) n_ref1++;
        if (fb1 === 1'b1) n_fb1++;
        if (ref2 === 1'b1) n_ref2++;
    end

    task automatic end_of_test();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Serial word, MSB first, each level held a full core cycle
    task automatic wr(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            @(negedge core_clk_i);
            ser_clk_i = 1'b0;
            ser_data_i = w[i];
            @(negedge core_clk_i);
            ser_clk_i = 1'b1;
        end
        @(negedge core_clk_i);
        ser_clk_i = 1'b0;
        @(negedge core_clk_i);
        ser_latch_i = 1'b1;
        @(negedge core_clk_i);
        ser_latch_i = 1'b0;
        @(negedge core_clk_i);
    endtask

    task automatic drv(input int k, input logic v);
        case (k)
            0: clk_in_i[0] = v;
            1: clk_in_i[1] = v;
            2: oscillator_input_i = v;
            4: clk_in_i[2] = v;
            default: vcxo_fb_i = v;
        endcase
    endtask

    // n rising edges on source k, then settle
    task automatic tog(input int k, input int n);
        for (int j = 0; j < n; j++) begin
            repeat (2) @(negedge core_clk_i);
            drv(k, 1'b1);
            repeat (2) @(negedge core_clk_i);
            drv(k, 1'b0);
        end
        repeat (4) @(negedge core_clk_i);
    endtask

    task automatic clr();
        @(negedge core_clk_i);
        n_ref1 = 0;
        n_fb1 = 0;
        n_ref2 = 0;
    endtask

    initial begin
        #1_000_000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        {rstn_i, ser_clk_i, ser_data_i, ser_latch_i, oscillator_input_i, vcxo_fb_i} = 6'h00;
        clk_in_i = 3'h0;
        active_input_i = 2'h0;
        loop1_in_window_i = 4'h1;
        loop2_in_window_i = 4'h4;
        ce_i = 1'b1;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (9) @(negedge core_clk_i);
        rstn_i = 1'b1;
        @(negedge core_clk_i);
        chk(32'(p1), 32'h0000_00C9);
        chk(32'(p2), 32'h0000_00C9);
        chk(32'(osc), 32'h0000_007F);
        chk({29'h0, lock1, lock2, protect}, 32'h0000_0000);
        foreach (rows[r]) begin
            wr(rows[r].word);
            chk(32'((rows[r].sel == 2'h0 ? 14'(p1) : rows[r].sel == 2'h1 ? 14'(p2) : 14'(osc))
                & rows[r].mask), 32'(rows[r].exp & rows[r].mask));
        end
        // ==========================================
        // Lock detect, both loops
        wr(32'h0000_00D9);
        tog(0, 2);
        chk(32'(lock1), 32'h0000_0000);
        tog(0, 1);
        chk(32'(lock1), 32'h0000_0001);
        loop1_in_window_i = 4'h2;
        tog(0, 1);
        chk(32'(lock1), 32'h0000_0000);
        wr(32'h0000_0058);
        tog(0, 3);
        chk(32'(lock1), 32'h0000_0001);
        wr(32'h8000_009A);
        tog(2, 1);
        chk(32'(lock2), 32'h0000_0000);
        tog(2, 1);
        chk(32'(lock2), 32'h0000_0001);
        // ==========================================
        // Dividers and input switch
        wr(32'h0010_009B);
        clr();
        tog(0, 8);
        chk(32'(n_ref1), 32'h0000_0002);
        active_input_i = 2'h1;
        clr();
        tog(1, 4);
        chk(32'(n_ref1), 32'h0000_0002);
        wr(32'h0300_005B);
        active_input_i = 2'h2;
        clr();
        tog(4, 16);
        chk(32'(n_ref1), 32'h0000_0002);
        wr(32'h0030_009C);
        clr();
        tog(2, 6);
        tog(3, 4);
        chk(32'(n_ref2), 32'h0000_0002);
        chk(32'(n_fb1), 32'h0000_0002);
        wr(32'hA000_009A);
        wr(32'h0010_005C);
        clr();
        tog(2, 2);
        chk(32'(n_ref2), 32'h0000_0004);
        ce_i = 1'b0;
        clr();
        tog(2, 2);
        ce_i = 1'b1;
        chk(32'(n_ref2), 32'h0000_0000);
        // ==========================================
        // Write protect, then reset in mid-run
        wr(32'h0000_003F);
        chk(32'(protect), 32'h0000_0001);
        wr(32'h0400_001D);
        chk(32'(osc.code), 32'h0000_0002);
        wr(32'h0000_001F);
        wr(32'h0400_001D);
        chk(32'(osc.code), 32'h0000_0004);
        rstn_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        chk({29'h0, lock1, lock2, protect}, 32'h0000_0000);
        chk(32'(osc), 32'h0000_007F);
        end_of_test();
    end
endmodule

`default_nettype wire
